/* File: common/shr_pkg.sv */
package shr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NV_WORDS = 5;
  localparam int IDX_W = 3;

  // holding register offsets on the register port
  localparam logic [7:0] OFS_CAL_CMD = 8'h01;
  localparam logic [7:0] OFS_SYS_CTRL = 8'h11;
  localparam logic [7:0] OFS_FUNC_CTRL = 8'h12;
  localparam logic [7:0] OFS_NODE_ADDR = 8'h13;
  localparam logic [7:0] OFS_SCALE_NUM = 8'h14;
  localparam logic [7:0] OFS_SCALE_DEN = 8'h15;
  localparam logic [7:0] OFS_CAL_TARGET = 8'h16;

  // word index inside the non-volatile store
  localparam logic [2:0] IDX_FUNC_CTRL = 3'h0;
  localparam logic [2:0] IDX_NODE_ADDR = 3'h1;
  localparam logic [2:0] IDX_SCALE_NUM = 3'h2;
  localparam logic [2:0] IDX_SCALE_DEN = 3'h3;
  localparam logic [2:0] IDX_CAL_TARGET = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // function control bit positions; a set bit in 0 to 4 turns its function off, bit 5 sets ready pin polarity
  localparam int FC_READY_OFF = 0;
  localparam int FC_ABC_OFF = 1;
  localparam int FC_STATIC_OFF = 2;
  localparam int FC_DYN_OFF = 3;
  localparam int FC_PRESS_OFF = 4;
  localparam int FC_READY_POL = 5;

  // factory values
  localparam logic [15:0] RST_FUNC_CTRL = 16'h0030;
  localparam logic [15:0] RST_NODE_ADDR = 16'h0068;
  localparam logic [15:0] RST_SCALE = 16'hFFFF;
  localparam logic [15:0] RST_CAL_TARGET = 16'h0000;

  localparam logic [15:0] NODE_ADDR_MIN = 16'h0001;
  localparam logic [15:0] NODE_ADDR_MAX = 16'h00F7;
  localparam logic [15:0] SCALE_OFF = 16'hFFFF;
  localparam logic [15:0] CMD_TARGET_CAL = 16'h7C05;
  localparam logic [15:0] SYS_RESTART = 16'h00FF;

  localparam logic [2:0] LOAD_LAST = 3'h5;
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN = 2'b11
  } shr_start_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_MUL = 2'b01,
    CS_DIV = 2'b11,
    CS_DONE = 2'b10
  } shr_calc_t;

  function automatic logic [15:0] factoryValue(input logic [2:0] idx);
    case (idx)
      IDX_FUNC_CTRL: factoryValue = RST_FUNC_CTRL;
      IDX_NODE_ADDR: factoryValue = RST_NODE_ADDR;
      IDX_SCALE_NUM: factoryValue = RST_SCALE;
      IDX_SCALE_DEN: factoryValue = RST_SCALE;
      default: factoryValue = RST_CAL_TARGET;
    endcase
  endfunction

endpackage

/* File: common/shr_nv_if.sv */
`timescale 1ns/100ps
interface shr_nv_if;
  logic wrEn;
  logic [2:0] wrIdx;
  logic [15:0] wrData;
  logic [2:0] rdIdx;
  logic [15:0] rdData;

  modport user (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
  modport store (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface

/* File: hw/shr_nv_store.sv */
`timescale 1ns/100ps
module shr_nv_store (
  // clock and power-on
  input wire logic clk_sys,
  input wire logic nPor,
  // store port
  shr_nv_if.store nv
);

  logic [15:0] mem [shr_pkg::NV_WORDS];

  // only power-on fills factory values; sensor resets leave the words alone
  genvar gi;
  generate
    for (gi = 0; gi < shr_pkg::NV_WORDS; gi++) begin : g_word
      always_ff @(posedge clk_sys or negedge nPor) begin
        if (!nPor) begin
          mem[gi] <= shr_pkg::factoryValue(3'(gi));
        end else if (nv.wrEn && nv.wrIdx == 3'(gi)) begin
          mem[gi] <= nv.wrData; // [R15]
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nPor) begin
    if (!nPor) begin
      nv.rdData <= 16'h0000;
    end else if (nv.rdIdx < 3'(shr_pkg::NV_WORDS)) begin
      nv.rdData <= mem[nv.rdIdx];
    end else begin
      nv.rdData <= 16'h0000;
    end
  end

endmodule

/* File: hw/shr_config_regs.sv */
`timescale 1ns/100ps
// Notes on behaviour
// R1 - bit0 set turns ready pin off
// R2 - bit1 set turns baseline calibration off
// R3 - bit2 set turns static filter off
// R4 - dynamic filter needs bits 2 and 3 clear
// R5 - bit4 clear enables pressure compensation; default off
// R6 - bit5 picks ready pin level while measuring
// R7 - node address 1 to 247, default 104
// R8 - new node address applies after reset only
// R9 - scaled equals raw times numerator over denominator
// R10 - numerator and denominator are unsigned 16 bit
// R11 - both all-ones means scaled copies raw
// R12 - bad scaling pair flagged at startup
// R13 - new scaling pair applies after reset only
// R14 - target command uses scaled calibration target; the code hands on the stored target word unscaled
// R15 - configuration words survive resets in store
// R16 - writing FF to system control restarts
// R17 - zero denominator counts as bad pair
module shr_config_regs (
  // clock, sensor reset, power-on fill of the store
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic nPor,
  // holding register port
  input wire logic [7:0] hrAddr,
  input wire logic hrWrite,
  input wire logic hrRead,
  input wire logic [15:0] hrWdata,
  output logic [15:0] hrRdata,
  output logic hrAck,
  output logic hrFault,
  output logic hrBusy,
  // concentration path
  input wire logic [15:0] rawConc,
  input wire logic rawValid,
  output logic [15:0] scaledConc,
  output logic scaledValid,
  // ready pin
  input wire logic measuring,
  output logic readyPinOut,
  output logic readyPinOe,
  // function enables seen by the measurement core
  output logic abcEnable,
  output logic staticIirEnable,
  output logic dynamicIirEnable,
  output logic pressureCompEnable,
  // live settings and events
  output logic [7:0] nodeAddress,
  output logic scaleFactorErr,
  output logic targetCalStart,
  output logic [15:0] targetCalValue,
  output logic sensorRestart
);

  shr_nv_if nv ();

  shr_nv_store u_store (
    .clk_sys(clk_sys),
    .nPor(nPor),
    .nv(nv.store)
  );

  function automatic logic [2:0] offsetToIdx(input logic [7:0] ofs);
    case (ofs)
      shr_pkg::OFS_FUNC_CTRL: offsetToIdx = shr_pkg::IDX_FUNC_CTRL;
      shr_pkg::OFS_NODE_ADDR: offsetToIdx = shr_pkg::IDX_NODE_ADDR;
      shr_pkg::OFS_SCALE_NUM: offsetToIdx = shr_pkg::IDX_SCALE_NUM;
      shr_pkg::OFS_SCALE_DEN: offsetToIdx = shr_pkg::IDX_SCALE_DEN;
      shr_pkg::OFS_CAL_TARGET: offsetToIdx = shr_pkg::IDX_CAL_TARGET;
      default: offsetToIdx = shr_pkg::IDX_NONE;
    endcase
  endfunction

  // startup sequencer
  shr_pkg::shr_start_t state;
  shr_pkg::shr_start_t next_state;
  logic [2:0] loadCnt;
  logic [15:0] shadow [shr_pkg::NV_WORDS];
  logic [15:0] actNum;
  logic [15:0] actDen;
  logic [7:0] actAddr;

  // register port decode
  wire logic [2:0] accIdx = offsetToIdx(hrAddr);
  wire logic isNvReg = (accIdx != shr_pkg::IDX_NONE);
  wire logic isCalCmd = (hrAddr == shr_pkg::OFS_CAL_CMD);
  wire logic isSysCtrl = (hrAddr == shr_pkg::OFS_SYS_CTRL);
  wire logic mapped = isNvReg || isCalCmd || isSysCtrl;
  wire logic running = (state == shr_pkg::ST_RUN);
  wire logic access = hrWrite || hrRead;
  wire logic addrInRange = (hrWdata >= shr_pkg::NODE_ADDR_MIN) &&
                           (hrWdata <= shr_pkg::NODE_ADDR_MAX);
  // out-of-range node addresses are refused, not clipped
  wire logic badValue = isNvReg && (accIdx == shr_pkg::IDX_NODE_ADDR) && !addrInRange; // [R7]
  wire logic refuse = access && (!running || !mapped || (hrWrite && badValue));
  wire logic nvWrite = hrWrite && running && isNvReg && !badValue;
  wire logic restartReq = hrWrite && running && isSysCtrl &&
                          (hrWdata == shr_pkg::SYS_RESTART); // [R16]
  wire logic calReq = hrWrite && running && isCalCmd &&
                      (hrWdata == shr_pkg::CMD_TARGET_CAL); // [R14]
  wire logic [15:0] readWord = (hrRead && running && isNvReg) ? shadow[accIdx] : 16'h0000;

  // store traffic: host writes go straight through, loads walk the words
  wire logic loading = (state == shr_pkg::ST_LOAD);
  wire logic loadCapture = loading && (loadCnt != 3'h0);
  wire logic [2:0] loadCapIdx = loadCnt - 3'h1;

  assign nv.wrEn = nvWrite; // [R15]
  assign nv.wrIdx = accIdx;
  assign nv.wrData = hrWdata;
  assign nv.rdIdx = (loading && loadCnt < shr_pkg::LOAD_LAST) ? loadCnt : shr_pkg::IDX_NONE;

  always_comb begin
    next_state = state;
    unique case (state)
      shr_pkg::ST_LOAD: begin
        if (loadCnt == shr_pkg::LOAD_LAST) begin
          next_state = shr_pkg::ST_CHECK;
        end
      end
      shr_pkg::ST_CHECK: begin
        next_state = shr_pkg::ST_RUN;
      end
      shr_pkg::ST_RUN: begin
        if (restartReq) begin
          next_state = shr_pkg::ST_LOAD;
        end
      end
      default: begin
        next_state = shr_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= shr_pkg::ST_LOAD;
      loadCnt <= 3'h0;
    end else begin
      state <= next_state;
      loadCnt <= loading ? loadCnt + 3'h1 : 3'h0;
    end
  end

  // shadow copy of the store; read data always comes from here
  genvar gi;
  generate
    for (gi = 0; gi < shr_pkg::NV_WORDS; gi++) begin : g_shadow
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          shadow[gi] <= 16'h0000;
        end else if (loadCapture && loadCapIdx == 3'(gi)) begin
          shadow[gi] <= nv.rdData;
        end else if (nvWrite && accIdx == 3'(gi)) begin
          shadow[gi] <= hrWdata;
        end
      end
    end
  endgenerate

  // address and scaling pair are latched only on the way out of startup,
  // so later writes wait for the next restart
  wire logic [15:0] ldNum = shadow[shr_pkg::IDX_SCALE_NUM];
  wire logic [15:0] ldDen = shadow[shr_pkg::IDX_SCALE_DEN];
  wire logic pairBypass = (ldNum == shr_pkg::SCALE_OFF) && (ldDen == shr_pkg::SCALE_OFF);
  wire logic pairBad = !pairBypass && (ldDen == 16'h0000); // [R17]

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      actNum <= shr_pkg::RST_SCALE;
      actDen <= shr_pkg::RST_SCALE;
      actAddr <= shr_pkg::RST_NODE_ADDR[7:0];
    end else if (state == shr_pkg::ST_CHECK) begin
      actNum <= ldNum; // [R13]
      actDen <= ldDen; // [R13]
      actAddr <= shadow[shr_pkg::IDX_NODE_ADDR][7:0]; // [R8]
    end
  end

  // rebuilt on every startup, so fixing the pair and restarting clears it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scaleFactorErr <= 1'b0;
    end else if (state == shr_pkg::ST_CHECK) begin
      scaleFactorErr <= pairBad; // [R12]
    end
  end

  // register port answer, one cycle after the request
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hrAck <= 1'b0;
      hrFault <= 1'b0;
      hrRdata <= 16'h0000;
      hrBusy <= 1'b1;
    end else begin
      hrAck <= access;
      hrFault <= refuse;
      hrRdata <= readWord;
      hrBusy <= (next_state != shr_pkg::ST_RUN);
    end
  end

  // one-cycle strobes to the core; the target word is frozen with its strobe
  // so a later host write cannot change a calibration already under way
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sensorRestart <= 1'b0;
      targetCalStart <= 1'b0;
      targetCalValue <= 16'h0000;
    end else begin
      sensorRestart <= restartReq; // [R16]
      targetCalStart <= calReq;
      if (calReq) begin
        targetCalValue <= shadow[shr_pkg::IDX_CAL_TARGET]; // [R14]
      end
    end
  end

  // function control decode; a cleared bit enables its function
  wire logic [15:0] fc = shadow[shr_pkg::IDX_FUNC_CTRL];
  wire logic next_abcEnable = running && !fc[shr_pkg::FC_ABC_OFF]; // [R2]
  wire logic next_staticIir = running && !fc[shr_pkg::FC_STATIC_OFF]; // [R3]
  wire logic next_dynamicIir = next_staticIir && !fc[shr_pkg::FC_DYN_OFF]; // [R4]
  wire logic next_pressComp = running && !fc[shr_pkg::FC_PRESS_OFF]; // [R5]
  wire logic next_readyOe = running && !fc[shr_pkg::FC_READY_OFF]; // [R1]
  // polarity set: high while measuring; cleared: low while measuring
  wire logic next_readyLevel = fc[shr_pkg::FC_READY_POL] ? measuring : !measuring; // [R6]

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      abcEnable <= 1'b0;
      staticIirEnable <= 1'b0;
      dynamicIirEnable <= 1'b0;
      pressureCompEnable <= 1'b0;
    end else begin
      abcEnable <= next_abcEnable;
      staticIirEnable <= next_staticIir;
      dynamicIirEnable <= next_dynamicIir;
      pressureCompEnable <= next_pressComp;
    end
  end

  // pin level follows measuring one cycle late; address holds between restarts
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      readyPinOe <= 1'b0;
      readyPinOut <= 1'b0;
      nodeAddress <= shr_pkg::RST_NODE_ADDR[7:0];
    end else begin
      readyPinOe <= next_readyOe;
      readyPinOut <= next_readyLevel;
      nodeAddress <= actAddr; // [R8]
    end
  end

  // scaling engine: one multiply cycle, then a 32-step restoring divide.
  // samples that arrive while it works are dropped; the core produces one
  // sample per measurement, far slower than the 34 cycles needed here
  shr_pkg::shr_calc_t calc;
  shr_pkg::shr_calc_t next_calc;
  logic [15:0] rawHold;
  logic [31:0] quo;
  logic [16:0] rem;
  logic [5:0] stepCnt;
  logic bypassHold;

  wire logic actBypass = (actNum == shr_pkg::SCALE_OFF) && (actDen == shr_pkg::SCALE_OFF); // [R11]
  wire logic actBad = (actDen == 16'h0000);
  wire logic takeRaw = rawValid && running && (calc == shr_pkg::CS_IDLE);
  wire logic [31:0] product = 32'(rawHold) * 32'(actNum); // [R10]
  wire logic [16:0] remShift = {rem[15:0], quo[31]};
  wire logic remFits = (remShift >= {1'b0, actDen}); // [R10]
  wire logic [16:0] remNext = remFits ? remShift - {1'b0, actDen} : remShift;
  wire logic [15:0] quoClip = (quo[31:16] != 16'h0000) ? 16'hFFFF : quo[15:0];

  always_comb begin
    next_calc = calc;
    unique case (calc)
      shr_pkg::CS_IDLE: begin
        if (takeRaw) begin
          next_calc = (actBypass || actBad) ? shr_pkg::CS_DONE : shr_pkg::CS_MUL;
        end
      end
      shr_pkg::CS_MUL: begin
        next_calc = shr_pkg::CS_DIV;
      end
      shr_pkg::CS_DIV: begin
        if (stepCnt == shr_pkg::DIV_STEPS - 6'h01) begin
          next_calc = shr_pkg::CS_DONE;
        end
      end
      shr_pkg::CS_DONE: begin
        next_calc = shr_pkg::CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      calc <= shr_pkg::CS_IDLE;
      rawHold <= 16'h0000;
      bypassHold <= 1'b0;
    end else begin
      calc <= next_calc;
      if (takeRaw) begin
        rawHold <= rawConc;
        bypassHold <= actBypass || actBad; // [R11]
      end
    end
  end

  // quotient and dividend share one shift register to save 32 flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      quo <= 32'h00000000;
      rem <= 17'h00000;
      stepCnt <= 6'h00;
    end else if (calc == shr_pkg::CS_MUL) begin
      quo <= product; // [R9]
      rem <= 17'h00000;
      stepCnt <= 6'h00;
    end else if (calc == shr_pkg::CS_DIV) begin
      quo <= {quo[30:0], remFits}; // [R9]
      rem <= remNext;
      stepCnt <= stepCnt + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scaledConc <= 16'h0000;
      scaledValid <= 1'b0;
    end else begin
      scaledValid <= (calc == shr_pkg::CS_DONE);
      if (calc == shr_pkg::CS_DONE) begin
        scaledConc <= bypassHold ? rawHold : quoClip; // [R9] [R11]
      end
    end
  end

endmodule

/* File: tb/shr_config_regs_assertions.sv */
`timescale 1ns/100ps
module shr_config_regs_assertions (
  // clock and resets
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic nPor,
  // register port
  input wire logic [7:0] hrAddr,
  input wire logic hrWrite,
  input wire logic [15:0] hrWdata,
  input wire logic hrFault,
  input wire logic hrBusy,
  // concentration path
  input wire logic [15:0] rawConc,
  input wire logic rawValid,
  input wire logic [15:0] scaledConc,
  input wire logic scaledValid,
  // pin and enables
  input wire logic measuring,
  input wire logic readyPinOut,
  input wire logic readyPinOe,
  input wire logic abcEnable,
  input wire logic staticIirEnable,
  input wire logic dynamicIirEnable,
  input wire logic pressureCompEnable,
  // settings and events
  input wire logic [7:0] nodeAddress,
  input wire logic scaleFactorErr,
  input wire logic targetCalStart,
  input wire logic sensorRestart
);
  logic [15:0] fc, num, den, aNum, aDen;
  logic [1:0] age;
  logic eng;
  wire wrOk = hrWrite && !hrBusy;
  wire fcWr = wrOk && hrAddr == shr_pkg::OFS_FUNC_CTRL;
  wire bypass = aNum == 16'hFFFF && aDen == 16'hFFFF;
  wire bad = aDen == 16'h0000 && !bypass;
  wire take = rawValid && !hrBusy && !eng;
  wire calm = age == 2'h3;
  // shadows follow the store, so only power-on loads their factory values
  always_ff @(posedge clk_sys or negedge nPor) begin
    if (!nPor) begin
      fc <= 16'h0030;
      num <= 16'hFFFF;
      den <= 16'hFFFF;
    end else if (wrOk) begin
      case (hrAddr)
        shr_pkg::OFS_FUNC_CTRL: fc <= hrWdata;
        shr_pkg::OFS_SCALE_NUM: num <= hrWdata;
        shr_pkg::OFS_SCALE_DEN: den <= hrWdata;
        default: ;
      endcase
    end
  end
  // the active pair is whatever the store holds while startup runs
  always_ff @(posedge clk_sys) begin
    if (hrBusy) begin
      aNum <= num;
      aDen <= den;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      age <= 2'h0;
      eng <= 1'b0;
    end else begin
      age <= (hrBusy || fcWr) ? 2'h0 : (calm ? age : age + 2'h1);
      eng <= hrBusy ? 1'b0 : (take ? 1'b1 : (scaledValid ? 1'b0 : eng));
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  range_fault_a: assert property (wrOk && hrAddr == shr_pkg::OFS_NODE_ADDR &&
    (hrWdata < 16'h0001 || hrWdata > 16'h00F7) |=> hrFault) else $error("address accepted");
  addr_hold_a: assert property (!hrBusy && !$past(hrBusy) && !$past(hrBusy, 2) |->
    $stable(nodeAddress)) else $error("node address moved while running");
  ready_en_a: assert property (calm |-> readyPinOe == !fc[0] && pressureCompEnable == !fc[4])
    else $error("ready or pressure enable wrong");
  abc_en_a: assert property (calm |-> abcEnable == !fc[1] && staticIirEnable == !fc[2])
    else $error("calibration or static filter enable wrong");
  dyn_en_a: assert property (calm |-> dynamicIirEnable == (!fc[2] && !fc[3]))
    else $error("dynamic filter enable wrong");
  pin_level_a: assert property (calm && readyPinOe && $stable(measuring) |->
    readyPinOut == (fc[5] ~^ measuring)) else $error("ready pin level wrong");
  copy_out_a: assert property (take && (bypass || bad) |-> ##2
    scaledValid && scaledConc == $past(rawConc, 2)) else $error("raw copy wrong");
  scale_time_a: assert property (take && !bypass && !bad |-> ##35 scaledValid)
    else $error("scaled result late");
  scale_err_a: assert property (!hrBusy && !$past(hrBusy) |-> scaleFactorErr == bad)
    else $error("scale error flag wrong");
  cal_start_a: assert property (wrOk && hrAddr == shr_pkg::OFS_CAL_CMD &&
    hrWdata == shr_pkg::CMD_TARGET_CAL |=> targetCalStart) else $error("no target start");
  restart_a: assert property (wrOk && hrAddr == shr_pkg::OFS_SYS_CTRL &&
    hrWdata == shr_pkg::SYS_RESTART |=> sensorRestart ##[0:2] hrBusy) else $error("no restart");
  cover property (sensorRestart);
  cover property (take && bad);
  cover property (hrFault);
endmodule
bind shr_config_regs shr_config_regs_assertions i_shr_config_regs_assertions (.clk_sys, .nrst,
  .nPor, .hrAddr, .hrWrite, .hrWdata, .hrFault, .hrBusy, .rawConc, .rawValid, .scaledConc,
  .scaledValid, .measuring, .readyPinOut, .readyPinOe, .abcEnable, .staticIirEnable,
  .dynamicIirEnable, .pressureCompEnable, .nodeAddress, .scaleFactorErr, .targetCalStart,
  .sensorRestart);

/* File: tb/shr_host_model.sv */
`timescale 1ns/100ps
module shr_host_model (
  // clock
  input wire logic clk_sys,
  // request
  output logic [7:0] hrAddr,
  output logic hrWrite,
  output logic hrRead,
  output logic [15:0] hrWdata,
  // answer
  input wire logic [15:0] hrRdata,
  input wire logic hrAck,
  input wire logic hrFault
);
  initial begin
    hrAddr = 8'h00;
    hrWrite = 1'b0;
    hrRead = 1'b0;
    hrWdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q, output logic f, output logic ok);
    ok = 1'b0;
    q = 16'h0000;
    f = 1'b0;
    @(posedge clk_sys);
    hrWrite <= w;
    hrRead <= !w;
    hrAddr <= a;
    hrWdata <= d;
    @(posedge clk_sys);
    hrWrite <= 1'b0;
    hrRead <= 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk_sys);
      if (hrAck === 1'b1) begin
        ok = 1'b1;
        q = hrRdata;
        f = hrFault;
      end
    end
    // released lines show the inverse so a stale value never looks fresh
    hrAddr <= ~a;
    hrWdata <= ~d;
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic nPor = 1'b0;
  logic [7:0] hrAddr, nodeAddress;
  logic [15:0] hrWdata, hrRdata, scaledConc, targetCalValue, q, v, num, den, na;
  logic [15:0] rawConc = 16'h0000;
  logic rawValid = 1'b0;
  logic measuring = 1'b0;
  logic hrWrite, hrRead, hrAck, hrFault, hrBusy, scaledValid, readyPinOut, readyPinOe;
  logic abcEnable, staticIirEnable, dynamicIirEnable, pressureCompEnable;
  logic scaleFactorErr, targetCalStart, sensorRestart;
  logic [15:0] fact [5] = '{16'h0030, 16'h0068, 16'hFFFF, 16'hFFFF, 16'h0000};
  int errCount = 0;
  int comparisons = 0;
  always #10 clk_sys = ~clk_sys;
  shr_config_regs i_shr_config_regs (.clk_sys, .nrst, .nPor, .hrAddr, .hrWrite, .hrRead,
    .hrWdata, .hrRdata, .hrAck, .hrFault, .hrBusy, .rawConc, .rawValid, .scaledConc,
    .scaledValid, .measuring, .readyPinOut, .readyPinOe, .abcEnable, .staticIirEnable,
    .dynamicIirEnable, .pressureCompEnable, .nodeAddress, .scaleFactorErr, .targetCalStart,
    .targetCalValue, .sensorRestart);
  shr_host_model i_shr_host_model (.clk_sys, .hrAddr, .hrWrite, .hrRead, .hrWdata, .hrRdata,
    .hrAck, .hrFault);
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
    input logic expF, output logic [15:0] rd);
    logic f, ok;
    i_shr_host_model.xfer(w, a, d, rd, f, ok);
    chk("answer", {15'h0, ok}, 16'h0001);
    chk("fault", {15'h0, f}, {15'h0, expF});
  endtask
  task automatic waitRun;
    for (int n = 0; n < 50 && hrBusy !== 1'b0; n++) @(posedge clk_sys);
    if (hrBusy !== 1'b0) begin
      errCount++;
      printVerdict();
    end
    // live address settles one edge after busy drops; the flag moves on the same edge as busy
    @(posedge clk_sys);
  endtask
  function automatic logic [15:0] scl(input logic [15:0] r, input logic [15:0] n,
    input logic [15:0] d);
    logic [31:0] p;
    p = ({16'h0, r} * {16'h0, n}) / {16'h0, d};
    // big ratios saturate rather than wrap
    scl = (p > 32'hFFFF) ? 16'hFFFF : p[15:0];
  endfunction
  function automatic logic [4:0] fen(input logic [15:0] f);
    fen = {!f[0], !f[1], !f[2], !f[2] && !f[3], !f[4]};
  endfunction
  task automatic sample(input logic [15:0] r, input logic [15:0] exp);
    @(posedge clk_sys);
    rawConc <= r;
    rawValid <= 1'b1;
    @(posedge clk_sys);
    rawValid <= 1'b0;
    rawConc <= ~r;
    for (int n = 0; n < 40 && scaledValid !== 1'b1; n++) @(posedge clk_sys);
    chk("scaled valid", {15'h0, scaledValid}, 16'h0001);
    chk("scaled", scaledConc, exp);
  endtask
  initial begin
    q = 16'($urandom(32'hBC9D));
    repeat (12) @(posedge clk_sys);
    nPor <= 1'b1;
    nrst <= 1'b1;
    waitRun();
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 8'h12 + 8'(i), 16'h0000, 1'b0, q);
      chk("factory word", q, fact[i]);
    end
    acc(1'b0, 8'h40, 16'h0000, 1'b1, q);
    chk("node", {8'h00, nodeAddress}, 16'h0068);
    $display("test factory done");
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 16'h0000 : ((i == 1) ? 16'h003E : 16'($urandom) & 16'h003F);
      acc(1'b1, 8'h12, v, 1'b0, q);
      measuring <= 1'($urandom);
      repeat (3) @(posedge clk_sys);
      chk("enables", {11'h0, readyPinOe, abcEnable, staticIirEnable, dynamicIirEnable,
        pressureCompEnable}, {11'h0, fen(v)});
      if (!v[0]) chk("pin", {15'h0, readyPinOut}, {15'h0, v[5] ~^ measuring});
    end
    $display("test function control done");
    acc(1'b1, 8'h13, 16'h0000, 1'b1, q);
    acc(1'b1, 8'h13, 16'h00F8, 1'b1, q);
    na = 16'h0001 + 16'($urandom_range(246));
    acc(1'b1, 8'h13, na, 1'b0, q);
    num = 16'($urandom) | 16'h0001;
    acc(1'b1, 8'h14, num, 1'b0, q);
    acc(1'b1, 8'h15, 16'h0000, 1'b0, q);
    v = 16'($urandom);
    sample(v, v);
    chk("node", {8'h00, nodeAddress}, 16'h0068);
    acc(1'b1, 8'h11, 16'h00FF, 1'b0, q);
    chk("restart pulse", {15'h0, sensorRestart}, 16'h0001);
    repeat (2) @(posedge clk_sys);
    chk("restart busy", {15'h0, hrBusy}, 16'h0001);
    waitRun();
    chk("node", {8'h00, nodeAddress}, na);
    chk("scale err", {15'h0, scaleFactorErr}, 16'h0001);
    sample(~v, ~v);
    $display("test pending settings done");
    den = 16'h0001 + 16'($urandom_range(255));
    acc(1'b1, 8'h15, den, 1'b0, q);
    nrst <= 1'b0;
    @(posedge clk_sys);
    nrst <= 1'b1;
    waitRun();
    acc(1'b0, 8'h14, 16'h0000, 1'b0, q);
    chk("kept num", q, num);
    chk("scale err", {15'h0, scaleFactorErr}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'hFFFF : 16'($urandom);
      sample(v, scl(v, num, den));
    end
    $display("test scaling done");
    v = 16'($urandom);
    acc(1'b1, 8'h16, v, 1'b0, q);
    acc(1'b1, 8'h01, 16'h7C05, 1'b0, q);
    chk("cal start", {15'h0, targetCalStart}, 16'h0001);
    chk("cal value", targetCalValue, v);
    acc(1'b1, 8'h01, 16'h1234, 1'b0, q);
    chk("cal idle", {15'h0, targetCalStart}, 16'h0000);
    $display("test target calibration done");
    printVerdict();
  end
endmodule
